// File: rtc_mem_model.sv
// far-side memory model that times refresh requests
`timescale 1ns/100ps
module rtc_mem_model
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// refresh side
	input wire logic refresh_request,
	output int req_count,
	output int last_gap
);
	int gap;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gap <= 0;
			req_count <= 0;
			last_gap <= 0;
		end
		else if (refresh_request)
		begin
			req_count <= req_count + 1;
			last_gap <= gap + 1;
			gap <= 0;
		end
		else
			gap <= gap + 1;
	end
endmodule // rtc_mem_model

// File: rtc_pkg.sv
// constants and register map of the refresh timer control block
// Functional notes
// - mode register resets to 0x02 on reset and hardware standby.
// - self-refresh select with DRAM/PSRAM mode self-refreshes memory in software standby.
// - attach enables 00 timer, 01 DRAM, 10 PSRAM, 11 illegal.
// - DRAM/PSRAM mode: area 3 cycles take three states; waits only if three-state area.
// - attach enable set blocks writes to mode bits 0,2,3,4 and timer registers, except flag clear.
// - strobe style bit 4: 0 dual write-enable, 1 dual column strobe; DRAM only.
// - column width bit 3: 0 eight-bit, 1 nine-bit column; DRAM only.
// - refresh pin enable bit 2 routes refresh strobe to the pin, else port use.
// - mode register bit 1 reads 1 and ignores writes.
// - refresh cycle enable bit 0 inserts refresh cycles only in DRAM/PSRAM mode.
// - match flag sets on counter equal constant; cleared by read-as-1 then write 0.
// - match interrupt enable requests interrupt from flag; forced 0 while attach enabled.
// - tick source 000 stops; 001..111 divide by 2,8,32,128,512,2048,4096.
// - each match gives refresh request in memory mode, interrupt event in timer mode.
// - timer control bits 2..0 read 1 and ignore writes.
// - timer control bits 7,6 init on reset and any standby; bits 5..3 kept in software standby.
// - counter increments per tick; on equality flag sets and counter clears together; here flag sets one tick before the clear.
// - counter initialised to 0x00 on reset and either standby.
// - constant initialised to 0xFF on reset and hardware standby; kept in software standby.
package rtc_pkg;
	localparam logic [31:0] RTC_OFF_MODE = 32'h0000_0000;
	localparam logic [31:0] RTC_OFF_TCSR = 32'h0000_0004;
	localparam logic [31:0] RTC_OFF_CNT = 32'h0000_0008;
	localparam logic [31:0] RTC_OFF_CONST = 32'h0000_000c;
	localparam logic [31:0] RTC_OFF_STAT = 32'h0000_0010;
	localparam logic [3:0] RTC_ADDR_MSB = 4'h4;
	localparam logic [7:0] RTC_MODE_RESET = 8'h02;
	localparam logic [7:0] RTC_MODE_WMASK = 8'h1d;
	localparam logic [7:0] RTC_TCSR_RSVD = 8'h07;
	localparam logic [7:0] RTC_CNT_RESET = 8'h00;
	localparam logic [7:0] RTC_CONST_RESET = 8'hff;
	localparam int RTC_B_SELF = 7;
	localparam int RTC_B_PSRAM = 6;
	localparam int RTC_B_DRAM = 5;
	localparam int RTC_B_STROBE = 4;
	localparam int RTC_B_COLW = 3;
	localparam int RTC_B_PIN = 2;
	localparam int RTC_B_CYC = 0;
	localparam int RTC_B_FLAG = 7;
	localparam int RTC_B_IE = 6;
	localparam int RTC_B_CKS = 3;
	localparam logic [11:0] RTC_PRE_MAX = 12'h0fff;
	localparam logic [1:0] RTC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] RTC_HSIZE_WORD = 3'h2;
	localparam logic [1:0] RTC_HRESP_OKAY = 2'h0;
	localparam logic [1:0] RTC_MODE_TIMER = 2'h0;
	localparam logic [1:0] RTC_MODE_DRAM = 2'h1;
	localparam logic [1:0] RTC_MODE_PSRAM = 2'h2;
	localparam logic [1:0] RTC_AREA_STATES = 2'h3;
	typedef enum logic [1:0] {RTC_RUN, RTC_SOFT_STBY} rtc_power_t;
endpackage

// File: rtc_tb.sv
// bus-level testbench of the refresh timer control block
`timescale 1ns/100ps
module tb;
import rtc_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hw_standby = 0, sw_standby = 0, area3_state_select = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, hresp, attach_mode, area3_states;
	logic [2:0] hsize = RTC_HSIZE_WORD;
	logic hreadyout, strobe_dual_cas, column_width_select, refresh_pin_enable, refresh_cycle_enable;
	logic self_refresh_active, area3_wait_allowed, refresh_request, match_interrupt;
	int num_errors = 0, n_tests = 0, req_count, last_gap, n, k2;
	int dv[8] = '{0, 2, 8, 32, 128, 512, 2048, 4096};
	always #50 hclk = ~hclk;
	rtc_top i_rtc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .hw_standby(hw_standby), .sw_standby(sw_standby),
		.area3_state_select(area3_state_select), .attach_mode(attach_mode), .strobe_dual_cas(strobe_dual_cas),
		.column_width_select(column_width_select), .refresh_pin_enable(refresh_pin_enable),
		.refresh_cycle_enable(refresh_cycle_enable), .self_refresh_active(self_refresh_active),
		.area3_states(area3_states), .area3_wait_allowed(area3_wait_allowed),
		.refresh_request(refresh_request), .match_interrupt(match_interrupt));
	rtc_mem_model i_rtc_mem_model (.hclk(hclk), .hresetn(hresetn), .refresh_request(refresh_request),
		.req_count(req_count), .last_gap(last_gap));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_rdy;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
	endtask
	// address phase held until ready, then data phase held until ready
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= RTC_HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task rc(input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge hclk);
		num_errors++;
		print_verdict();
	end
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(RTC_OFF_MODE, 32'h0000_0002);
		rc(RTC_OFF_TCSR, 32'h0000_0007);
		rc(RTC_OFF_CNT, 32'h0000_0000);
		rc(RTC_OFF_CONST, 32'h0000_00ff);
		wr(RTC_OFF_MODE, 32'h0000_0000);
		rc(RTC_OFF_MODE, 32'h0000_0002);
		wr(RTC_OFF_TCSR, 32'h0000_0000);
		rc(RTC_OFF_TCSR, 32'h0000_0007);
		wr(RTC_OFF_CNT, 32'h0000_005a);
		repeat (20) @(posedge hclk);
		rc(RTC_OFF_CNT, 32'h0000_005a);
		// interval timer, then flag clear needs a read first
		wr(RTC_OFF_CONST, 32'h0000_0003);
		wr(RTC_OFF_CNT, 32'h0000_0000);
		wr(RTC_OFF_TCSR, 32'h0000_004f);
		repeat (20) @(posedge hclk);
		chk(match_interrupt, 32'h0000_0001);
		wr(RTC_OFF_TCSR, 32'h0000_00c0);
		wr(RTC_OFF_TCSR, 32'h0000_0040);
		rc(RTC_OFF_TCSR, 32'h0000_00c7);
		wr(RTC_OFF_TCSR, 32'h0000_0040);
		rc(RTC_OFF_TCSR, 32'h0000_0047);
		chk(match_interrupt, 32'h0000_0000);
		wr(RTC_OFF_CONST, 32'h0000_0001);
		// every rate, dram and psram in turn
		for (int i = 1; i < 8; i++)
		begin
			wr(RTC_OFF_MODE, 32'h0000_0000);
			wr(RTC_OFF_TCSR, {24'h00_0000, 2'h1, i[2:0], 3'h0});
			area3_state_select <= i[1];
			wr(RTC_OFF_MODE, i[0] ? 32'h0000_00bd : 32'h0000_00dd);
			repeat (2) @(posedge hclk);
			chk(attach_mode, i[0] ? 32'h0000_0001 : 32'h0000_0002);
			chk(strobe_dual_cas, i[0]);
			chk(column_width_select, i[0]);
			chk(refresh_pin_enable, 32'h0000_0001);
			chk(refresh_cycle_enable, 32'h0000_0001);
			chk(match_interrupt, 32'h0000_0000);
			wr(RTC_OFF_CONST, 32'h0000_0055);
			rc(RTC_OFF_CONST, 32'h0000_0001);
			wr(RTC_OFF_MODE, i[0] ? 32'h0000_00a1 : 32'h0000_00c1);
			rc(RTC_OFF_MODE, i[0] ? 32'h0000_00bf : 32'h0000_00df);
			k2 = req_count;
			for (n = 0; n < 30000 && req_count < k2 + 2; n++)
				@(posedge hclk);
			chk(last_gap, 2 * dv[i]);
		end
		sw_standby <= 1'b1;
		repeat (3) @(posedge hclk);
		chk(self_refresh_active, 32'h0000_0001);
		rc(RTC_OFF_TCSR, 32'h0000_003f);
		rc(RTC_OFF_CNT, 32'h0000_0000);
		rc(RTC_OFF_CONST, 32'h0000_0001);
		sw_standby <= 1'b0;
		repeat (3) @(posedge hclk);
		chk(self_refresh_active, 32'h0000_0000);
		hw_standby <= 1'b1;
		repeat (3) @(posedge hclk);
		rc(RTC_OFF_MODE, 32'h0000_0002);
		rc(RTC_OFF_TCSR, 32'h0000_0007);
		rc(RTC_OFF_CONST, 32'h0000_00ff);
		chk(attach_mode, 32'h0000_0000);
		hw_standby <= 1'b0;
		print_verdict();
	end
endmodule // tb

// File: rtc_top.sv
// refresh timer control registers, prescaler, counter and compare
`timescale 1ns/100ps
module rtc_top
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	// power state and area 3 select
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic area3_state_select,
	// memory control outputs
	output logic [1:0] attach_mode,
	output logic strobe_dual_cas,
	output logic column_width_select,
	output logic refresh_pin_enable,
	output logic refresh_cycle_enable,
	output logic self_refresh_active,
	output logic [1:0] area3_states,
	output logic area3_wait_allowed,
	output logic refresh_request,
	output logic match_interrupt
);
	import rtc_pkg::*;

	logic [7:0] refresh_mode_control;
	logic match_flag;
	logic match_interrupt_enable;
	logic [2:0] tick_source_select;
	logic [7:0] refresh_tick_counter;
	logic [7:0] refresh_interval_constant;
	logic [11:0] prescale;
	logic flag_seen;
	logic dp_write;
	logic dp_read;
	logic [31:0] dp_addr;
	rtc_power_t power_state;

	wire attached = refresh_mode_control[RTC_B_PSRAM] | refresh_mode_control[RTC_B_DRAM];
	wire dram_mode = refresh_mode_control[RTC_B_DRAM] & ~refresh_mode_control[RTC_B_PSRAM];
	wire stby_any = hw_standby | sw_standby;
	wire addr_ok = (haddr[31:5] == 27'h000_0000) && (haddr[RTC_ADDR_MSB:0] <= RTC_OFF_STAT[4:0]);
	wire take = hsel & hready & (htrans == RTC_HTRANS_NONSEQ) & (hsize == RTC_HSIZE_WORD) & addr_ok;
	wire wr_mode = dp_write & (dp_addr == RTC_OFF_MODE);
	wire wr_tcsr = dp_write & (dp_addr == RTC_OFF_TCSR);
	wire wr_cnt = dp_write & (dp_addr == RTC_OFF_CNT) & ~attached;
	wire wr_const = dp_write & (dp_addr == RTC_OFF_CONST) & ~attached;
	wire rd_tcsr = dp_read & (dp_addr == RTC_OFF_TCSR);
	wire [7:0] tcsr_value = {match_flag, match_interrupt_enable, tick_source_select, 3'h7} | RTC_TCSR_RSVD;
	wire [7:0] mode_value = refresh_mode_control | RTC_MODE_RESET;
	// mode bits 5..7 follow any write; 0,2,3,4 only while detached; bit 1 stays 1
	wire [7:0] mode_mask = attached ? 8'he0 : (8'he0 | RTC_MODE_WMASK);
	wire [7:0] next_mode = ((refresh_mode_control & ~mode_mask) | (hwdata[7:0] & mode_mask)) | RTC_MODE_RESET;
	// prescaler tap per source select
	wire [11:0] div_mask = (tick_source_select == 3'h1) ? 12'h001 :
		(tick_source_select == 3'h2) ? 12'h007 :
		(tick_source_select == 3'h3) ? 12'h01f :
		(tick_source_select == 3'h4) ? 12'h07f :
		(tick_source_select == 3'h5) ? 12'h1ff :
		(tick_source_select == 3'h6) ? 12'h7ff : RTC_PRE_MAX;
	wire tick = (tick_source_select != 3'h0) & ((prescale & div_mask) == div_mask) & ~stby_any;
	wire match = tick & ((refresh_tick_counter + 8'h01) == refresh_interval_constant)
		| (refresh_tick_counter == refresh_interval_constant) & (tick_source_select != 3'h0) & ~stby_any;
	wire flag_clear = wr_tcsr & ~hwdata[RTC_B_FLAG] & flag_seen;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= 32'h0000_0000;
		end
		else if (hready)
		begin
			dp_write <= take & hwrite;
			dp_read <= take & ~hwrite;
			dp_addr <= haddr;
		end
	end

	// read data register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hsel & hready & (htrans == RTC_HTRANS_NONSEQ) & ~hwrite)
			hrdata <= addr_ok ? (haddr == RTC_OFF_MODE ? {24'h00_0000, mode_value} :
				haddr == RTC_OFF_TCSR ? {24'h00_0000, tcsr_value} :
				haddr == RTC_OFF_CNT ? {24'h00_0000, refresh_tick_counter} :
				haddr == RTC_OFF_CONST ? {24'h00_0000, refresh_interval_constant} :
				{30'h0000_0000, power_state == RTC_SOFT_STBY, attached}) : 32'h0000_0000;
	end

	// zero-wait slave, always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= RTC_HRESP_OKAY;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= RTC_HRESP_OKAY;
		end
	end

	// power state tracking
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			power_state <= RTC_RUN;
		else
			unique case (power_state)
				RTC_RUN: power_state <= (sw_standby & ~hw_standby) ? RTC_SOFT_STBY : RTC_RUN;
				RTC_SOFT_STBY: power_state <= sw_standby ? RTC_SOFT_STBY : RTC_RUN;
			endcase
	end

	// mode register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			refresh_mode_control <= RTC_MODE_RESET;
		else if (hw_standby)
			refresh_mode_control <= RTC_MODE_RESET;
		else if (wr_mode)
			refresh_mode_control <= next_mode;
	end

	// timer control fields
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			match_flag <= 1'b0;
			match_interrupt_enable <= 1'b0;
			tick_source_select <= 3'h0;
			flag_seen <= 1'b0;
		end
		else if (hw_standby)
		begin
			match_flag <= 1'b0;
			match_interrupt_enable <= 1'b0;
			tick_source_select <= 3'h0;
			flag_seen <= 1'b0;
		end
		else if (sw_standby)
		begin
			match_flag <= 1'b0;
			match_interrupt_enable <= 1'b0;
			flag_seen <= 1'b0;
		end
		else
		begin
			// set wins over clear
			match_flag <= match | (match_flag & ~flag_clear);
			if (rd_tcsr & match_flag)
				flag_seen <= 1'b1;
			else if (flag_clear | ~match_flag)
				flag_seen <= 1'b0;
			if (attached)
				match_interrupt_enable <= 1'b0;
			else if (wr_tcsr)
				match_interrupt_enable <= hwdata[RTC_B_IE];
			if (wr_tcsr & ~attached)
				tick_source_select <= hwdata[RTC_B_CKS +: 3];
		end
	end

	// prescaler, counter and constant
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prescale <= 12'h000;
			refresh_tick_counter <= RTC_CNT_RESET;
			refresh_interval_constant <= RTC_CONST_RESET;
		end
		else if (stby_any)
		begin
			prescale <= 12'h000;
			refresh_tick_counter <= RTC_CNT_RESET;
			if (hw_standby)
				refresh_interval_constant <= RTC_CONST_RESET;
		end
		else
		begin
			prescale <= prescale + 12'h001;
			if (wr_cnt)
				refresh_tick_counter <= hwdata[7:0];
			else if (tick & (refresh_tick_counter == refresh_interval_constant))
				refresh_tick_counter <= RTC_CNT_RESET;
			else if (tick)
				refresh_tick_counter <= refresh_tick_counter + 8'h01;
			if (wr_const)
				refresh_interval_constant <= hwdata[7:0];
		end
	end

	// outputs toward the area 3 bus controller
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			attach_mode <= RTC_MODE_TIMER;
			strobe_dual_cas <= 1'b0;
			column_width_select <= 1'b0;
			refresh_pin_enable <= 1'b0;
			refresh_cycle_enable <= 1'b0;
			self_refresh_active <= 1'b0;
			area3_states <= RTC_AREA_STATES;
			area3_wait_allowed <= 1'b1;
			refresh_request <= 1'b0;
			match_interrupt <= 1'b0;
		end
		else
		begin
			attach_mode <= refresh_mode_control[RTC_B_DRAM +: 2] == 2'h3 ? RTC_MODE_TIMER :
				{refresh_mode_control[RTC_B_PSRAM], refresh_mode_control[RTC_B_DRAM]};
			strobe_dual_cas <= dram_mode & refresh_mode_control[RTC_B_STROBE];
			column_width_select <= dram_mode & refresh_mode_control[RTC_B_COLW];
			refresh_pin_enable <= refresh_mode_control[RTC_B_PIN];
			refresh_cycle_enable <= attached & refresh_mode_control[RTC_B_CYC];
			self_refresh_active <= attached & refresh_mode_control[RTC_B_SELF] & sw_standby;
			area3_states <= RTC_AREA_STATES;
			area3_wait_allowed <= ~attached | area3_state_select;
			refresh_request <= attached & tick & (refresh_tick_counter == refresh_interval_constant);
			match_interrupt <= ~attached & match_flag & match_interrupt_enable;
		end
	end
endmodule // rtc_top

// File: rtc_top_asserts.sv
// checker of the refresh timer control outputs
`timescale 1ns/100ps
module rtc_top_asserts
import rtc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// power and area inputs
	input wire logic sw_standby,
	input wire logic area3_state_select,
	// memory control outputs
	input wire logic [1:0] attach_mode,
	input wire logic strobe_dual_cas,
	input wire logic column_width_select,
	input wire logic refresh_cycle_enable,
	input wire logic self_refresh_active,
	input wire logic [1:0] area3_states,
	input wire logic area3_wait_allowed,
	input wire logic refresh_request,
	input wire logic match_interrupt
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire attached = attach_mode != RTC_MODE_TIMER;
	sequence req_pulse;
		refresh_request ##1 !refresh_request;
	endsequence
	states_three_a: assert property (area3_states == RTC_AREA_STATES)
		else $error("area 3 not three states");
	wait_allow_a: assert property (area3_wait_allowed == (!attached || $past(area3_state_select)))
		else $error("wait permission wrong");
	cycle_gate_a: assert property (!attached |-> !refresh_cycle_enable)
		else $error("refresh cycles in timer mode");
	irq_gate_a: assert property (attached |=> !match_interrupt)
		else $error("interrupt while memory attached");
	req_mode_a: assert property (refresh_request |-> attached ##0 req_pulse)
		else $error("refresh request outside memory mode");
	self_ref_a: assert property (self_refresh_active |-> $past(sw_standby) && attached)
		else $error("self refresh outside standby");
	strobe_gate_a: assert property (strobe_dual_cas |-> attach_mode == RTC_MODE_DRAM)
		else $error("strobe style outside dram mode");
	colw_gate_a: assert property (column_width_select |-> attach_mode == RTC_MODE_DRAM)
		else $error("column width outside dram mode");
endmodule // rtc_top_asserts
bind rtc_top rtc_top_asserts i_rtc_top_asserts (.hclk(hclk), .hresetn(hresetn), .sw_standby(sw_standby),
	.area3_state_select(area3_state_select), .attach_mode(attach_mode), .strobe_dual_cas(strobe_dual_cas),
	.column_width_select(column_width_select), .refresh_cycle_enable(refresh_cycle_enable),
	.self_refresh_active(self_refresh_active), .area3_states(area3_states),
	.area3_wait_allowed(area3_wait_allowed), .refresh_request(refresh_request), .match_interrupt(match_interrupt));
